// file: dv/ddrm_ctrl_model.sv
// controller model: link clock, commands and write bursts for the module
// assumes mclk_i at 125 MHz; one link cycle spans ten mclk cycles
module ddrm_ctrl_model
  import ddrm_pkg::*;
(
  // pacing clock
  input wire logic mclk_i,
  // link clock and command pins
  output logic true_clock_o,
  output logic complement_clock_o,
  output logic [RANKS-1:0] clock_enable_o,
  output logic [RANKS-1:0] rank_select_n_o,
  output logic [2:0] cmd_n_o,
  output logic [BANK_W-1:0] bank_o,
  output logic [ADDR_W-1:0] address_o,
  // write data pins
  output logic [DATA_W-1:0] dq_o,
  output logic data_strobe_o,
  output logic [MASK_W-1:0] write_byte_mask_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle pins: both ranks deselected, enables high, strobe parked low
  initial begin
    true_clock_o = 1'h0;
    complement_clock_o = 1'h1;
    clock_enable_o = 2'h3;
    rank_select_n_o = 2'h3;
    cmd_n_o = 3'h7;
    bank_o = 2'h0;
    address_o = 13'h0000;
    dq_o = 16'h0000;
    data_strobe_o = 1'h0;
    write_byte_mask_o = 2'h0;
  end

  // enables move only between accesses, never inside one
  task automatic set_cke(input logic [RANKS-1:0] cke);
    @(posedge mclk_i);
    clock_enable_o <= cke;
  endtask

  // one link cycle: rise after 40 ns, fall 40 ns later
  task automatic link_cycle();
    repeat (5) @(posedge mclk_i);
    true_clock_o <= 1'h1;
    complement_clock_o <= 1'h0;
    repeat (5) @(posedge mclk_i);
    true_clock_o <= 1'h0;
    complement_clock_o <= 1'h1;
  endtask

  // command held a full half period past the rise, then released
  task automatic issue(input logic [1:0] sel_n, input logic [2:0] code,
    input logic [1:0] bank, input logic [12:0] addr);
    @(posedge mclk_i);
    rank_select_n_o <= sel_n;
    cmd_n_o <= code;
    bank_o <= bank;
    address_o <= addr;
    link_cycle();
    rank_select_n_o <= 2'h3;
    cmd_n_o <= 3'h7;
    bank_o <= ~bank;
    address_o <= ~addr;
  endtask

  // two words per burst, strobe edges centred in each data eye
  task automatic burst(input logic [31:0] data, input logic [3:0] mask);
    @(posedge mclk_i);
    dq_o <= data[15:0];
    write_byte_mask_o <= mask[1:0];
    repeat (3) @(posedge mclk_i);
    data_strobe_o <= 1'h1;
    repeat (3) @(posedge mclk_i);
    dq_o <= data[31:16];
    write_byte_mask_o <= mask[3:2];
    repeat (3) @(posedge mclk_i);
    data_strobe_o <= 1'h0;
    repeat (3) @(posedge mclk_i);
    dq_o <= ~data[31:16];
    write_byte_mask_o <= ~mask[3:2];
  endtask
endmodule

// file: dv/testbench.sv
// self-checking bench for the ddr module command, power and data logic
// assumes ddrm_ctrl_model drives every link pin of the module
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ddrm_pkg::*;

  logic mclk_i;
  logic rst_n_i;
  logic tck, cck, dqs_w, dq_oe, dqs_r, dqs_oe, wr_ready;
  logic [1:0] cke, sel_n, bank, wmask;
  logic [2:0] cmd_n;
  logic [12:0] addr, mode, ext;
  logic [15:0] dq_w, dq_r;
  logic [7:0] bopen, pstate;
  int errors;
  int checks_done;

  // wire level of the shared data and strobe pins
  wire logic [15:0] dq_wire = dq_oe ? dq_r : dq_w;
  wire logic dqs_wire = dqs_oe ? dqs_r : dqs_w;
  // single pins split from the model's grouped outputs
  wire logic rs0_n = sel_n[0];
  wire logic rs1_n = sel_n[1];
  wire logic ras_n = cmd_n[2];
  wire logic cas_n = cmd_n[1];
  wire logic we_n = cmd_n[0];
  wire logic bank_lo = bank[0];
  wire logic bank_hi = bank[1];

  ddrm_ctrl_model i_ddrm_ctrl_model (.mclk_i(mclk_i),
    .true_clock_o(tck), .complement_clock_o(cck), .clock_enable_o(cke),
    .rank_select_n_o(sel_n), .cmd_n_o(cmd_n), .bank_o(bank),
    .address_o(addr), .dq_o(dq_w), .data_strobe_o(dqs_w),
    .write_byte_mask_o(wmask));

  ddrm_core i_ddrm_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .true_clock_i(tck), .complement_clock_i(cck), .clock_enable_i(cke),
    .rank_select_zero_n_i(rs0_n), .rank_select_one_n_i(rs1_n),
    .row_strobe_n_i(ras_n), .col_strobe_n_i(cas_n),
    .write_enable_n_i(we_n), .bank_select_low_i(bank_lo),
    .bank_select_high_i(bank_hi), .address_bus_i(addr), .dq_i(dq_wire),
    .dq_o(dq_r), .dq_oe_o(dq_oe), .data_strobe_i(dqs_wire),
    .data_strobe_o(dqs_r), .data_strobe_oe_o(dqs_oe),
    .write_byte_mask_i(wmask), .mode_reg_o(mode), .ext_mode_reg_o(ext),
    .bank_open_o(bopen), .power_state_o(pstate), .wr_ready_o(wr_ready));

  // core clock, 8 ns period
  initial begin
    mclk_i = 1'h0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic check_val(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // registered outputs land a few mclk after the crossing
  task automatic settle();
    repeat (3) @(negedge mclk_i);
  endtask

  task automatic cmd(input logic [1:0] s, input logic [2:0] c,
    input logic [1:0] b, input logic [12:0] a);
    i_ddrm_ctrl_model.issue(s, c, b, a);
    settle();
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // read on rank 0 with the link running; beats sampled as they appear
  task automatic read_check(input logic [1:0] b, input logic [12:0] a,
    input logic [31:0] exp);
    int n;
    n = 0;
    i_ddrm_ctrl_model.issue(2'h2, CMD_RD, b, a);
    fork
      repeat (4) i_ddrm_ctrl_model.link_cycle();
      begin
        @(negedge mclk_i);
        while (dq_oe !== 1'h1 && n < 60) begin
          @(negedge mclk_i);
          n++;
        end
        check_val(32'(n >= 24 && n <= 31), 32'h1, "latency");
        check_val({dqs_r, dqs_oe, dq_r}, {2'h3, exp[15:0]}, "low");
        n = 0;
        while (dqs_r !== 1'h0 && n < 20) begin
          @(negedge mclk_i);
          n++;
        end
        check_val({dq_oe, dq_r}, {1'h1, exp[31:16]}, "high");
      end
    join
    settle();
    check_val({dq_oe, dqs_oe}, 32'h0, "released");
  endtask

  task automatic s_reset();
    check_val({pstate, bopen, 15'h0, wr_ready}, 32'h1100_0001, "rst");
    check_val({mode, ext}, 32'h0, "rst mode");
  endtask

  // base, extended and an ignored mode select
  task automatic s_mode();
    cmd(2'h2, CMD_LMR, MODE_SEL_BASE, 13'h0032);
    cmd(2'h2, CMD_LMR, MODE_SEL_EXT, 13'h1A5C);
    cmd(2'h2, CMD_LMR, 2'h2, 13'h0FFF);
    check_val({mode, ext}, {13'h0032, 13'h1A5C}, "mode");
  endtask

  // deselected activate masked; per-rank banks; single and all precharge
  task automatic s_banks();
    cmd(2'h3, CMD_ACT, 2'h2, 13'h0100);
    check_val(bopen, 32'h0, "masked");
    cmd(2'h2, CMD_ACT, 2'h2, 13'h0100);
    check_val(bopen, 32'h04, "act");
    cmd(2'h1, CMD_ACT, 2'h1, 13'h0200);
    cmd(2'h2, CMD_ACT, 2'h0, 13'h0300);
    cmd(2'h2, CMD_ACT, 2'h1, 13'h0400);
    check_val(bopen, 32'h27, "banks");
    cmd(2'h2, CMD_PRE, 2'h0, 13'h0000);
    check_val(bopen, 32'h26, "pre one");
    cmd(2'h1, CMD_PRE, 2'h3, 13'h0400);
    check_val(bopen, 32'h06, "pre all");
  endtask

  // full write, masked overwrite, read back with auto precharge
  task automatic s_data();
    cmd(2'h2, CMD_WR, 2'h2, 13'h0001);
    i_ddrm_ctrl_model.burst(32'hA5C3_0F1E, 4'h0);
    cmd(2'h2, CMD_WR, 2'h2, 13'h0001);
    i_ddrm_ctrl_model.burst(32'h1122_3344, 4'h6);
    repeat (20) @(negedge mclk_i);
    read_check(2'h2, 13'h0401, 32'h11C3_0F44);
    check_val(bopen, 32'h02, "rd ap");
  endtask

  // active and precharge power-down, self refresh with async exit
  task automatic s_power();
    i_ddrm_ctrl_model.set_cke(2'h2);
    i_ddrm_ctrl_model.link_cycle();
    settle();
    check_val(pstate, 32'h14, "apd");
    cmd(2'h2, CMD_ACT, 2'h3, 13'h0000);
    check_val(bopen, 32'h02, "pd ignore");
    i_ddrm_ctrl_model.set_cke(2'h3);
    i_ddrm_ctrl_model.link_cycle();
    settle();
    check_val(pstate, 32'h11, "pd exit");
    cmd(2'h2, CMD_PRE, 2'h0, 13'h0400);
    i_ddrm_ctrl_model.set_cke(2'h2);
    i_ddrm_ctrl_model.link_cycle();
    settle();
    check_val(pstate, 32'h12, "ppd");
    i_ddrm_ctrl_model.set_cke(2'h3);
    i_ddrm_ctrl_model.link_cycle();
    i_ddrm_ctrl_model.set_cke(2'h2);
    cmd(2'h2, CMD_REF, 2'h0, 13'h0000);
    check_val(pstate, 32'h18, "sref");
    i_ddrm_ctrl_model.set_cke(2'h3);
    repeat (8) @(negedge mclk_i);
    check_val(pstate, 32'h11, "sref exit");
  endtask

  // drain held off by rank 1 enable low until the fifo refuses
  task automatic s_fifo();
    cmd(2'h2, CMD_ACT, 2'h0, 13'h0000);
    i_ddrm_ctrl_model.set_cke(2'h1);
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      cmd(2'h2, CMD_WR, 2'h0, 13'(k));
      i_ddrm_ctrl_model.burst({16'hBEEF, 16'(k)}, 4'h0);
    end
    settle();
    check_val(wr_ready, 32'h0, "full");
    i_ddrm_ctrl_model.set_cke(2'h3);
    repeat (40) @(negedge mclk_i);
    check_val(wr_ready, 32'h1, "drained");
  endtask

  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    rst_n_i = 1'h0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    repeat (4) @(negedge mclk_i);
    s_reset();
    s_mode();
    s_banks();
    s_data();
    s_power();
    s_fifo();
    print_verdict();
  end

  // run needs under 3000 mclk; a hang is cut well beyond that
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    print_verdict();
  end
endmodule

// file: hdl/ddrm_core.sv
// ddr module command, clock-enable and strobe/mask logic, two ranks
// assumes link pins asynchronous to mclk_i; link clock far slower than it
module ddrm_core
  import ddrm_pkg::*;
(
  // core clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // link clock and command pins
  input wire logic true_clock_i,
  input wire logic complement_clock_i,
  input wire logic [RANKS-1:0] clock_enable_i,
  input wire logic rank_select_zero_n_i,
  input wire logic rank_select_one_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_enable_n_i,
  input wire logic bank_select_low_i,
  input wire logic bank_select_high_i,
  input wire logic [ADDR_W-1:0] address_bus_i,
  // data, strobe and mask pins
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic data_strobe_i,
  output logic data_strobe_o,
  output logic data_strobe_oe_o,
  input wire logic [MASK_W-1:0] write_byte_mask_i,
  // status
  output logic [ADDR_W-1:0] mode_reg_o,
  output logic [ADDR_W-1:0] ext_mode_reg_o,
  output logic [OPEN_W-1:0] bank_open_o,
  output logic [RANKS*4-1:0] power_state_o,
  output logic wr_ready_o
);
  typedef struct packed {
    logic link_hi;
    logic dqs_q;
    ddrm_pwr_t [RANKS-1:0] pwr;
    logic [OPEN_W-1:0] bank_open;
    logic [ADDR_W-1:0] mode_reg;
    logic [ADDR_W-1:0] ext_mode;
    ddrm_rd_t rd_st;
    logic [RD_LAT_W-1:0] rd_cnt;
    logic [IDX_W-1:0] rd_idx;
    logic rd_rank;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
    logic wr_pend;
    logic wr_lo_ok;
    logic [IDX_W-1:0] wr_idx;
    logic wr_rank;
    logic [DATA_W-1:0] wr_lo;
    logic [MASK_W-1:0] wr_lo_mask;
    logic push_valid;
    logic [FIFO_W-1:0] push_data;
    logic wr_ready;
    logic [MEM_N-1:0][PAIR_W-1:0] mem;
  } ddrm_state_t;
  ddrm_state_t s;
  ddrm_state_t next_s;

  // synchronised pins
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] syn;
  logic tck_s;
  logic cck_s;
  logic [RANKS-1:0] cke_s;
  logic rs1_n_s;
  logic rs0_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic bah_s;
  logic bal_s;
  logic [ADDR_W-1:0] addr_s;
  logic dqs_s;
  logic [DATA_W-1:0] dq_s;
  logic [MASK_W-1:0] mask_s;
  // decode helpers
  logic rise;
  logic fall;
  logic dqs_rise;
  logic dqs_fall;
  logic [2:0] cmd;
  logic [BANK_W-1:0] ba;
  logic [RANKS-1:0] sel;
  logic ap;
  logic [RANKS-1:0] act_go;
  logic [RANKS-1:0] pre_go;
  logic rd_go;
  logic lmr_go;
  logic [IDX_W-1:0] pop_idx;
  logic [PMASK_W-1:0] pop_mask;
  logic [PAIR_W-1:0] pop_data;
  logic [BANKS-1:0] open0;

  ddrm_stream_if #(.W(FIFO_W)) wr_if();
  ddrm_stream_if #(.W(FIFO_W)) mem_if();

  // every pin passes two flops before any decode looks at it
  assign raw = {true_clock_i, complement_clock_i, clock_enable_i,
                rank_select_one_n_i, rank_select_zero_n_i, row_strobe_n_i,
                col_strobe_n_i, write_enable_n_i, bank_select_high_i,
                bank_select_low_i, address_bus_i, data_strobe_i, dq_i,
                write_byte_mask_i};
  assign {tck_s, cck_s, cke_s, rs1_n_s, rs0_n_s, ras_n_s, cas_n_s, we_n_s,
          bah_s, bal_s, addr_s, dqs_s, dq_s, mask_s} = syn;

  ddrm_sync #(.W(SYNC_W)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(raw),
    .q_o(syn)
  );

  // write pairs wait here until the array is free and clocks run
  ddrm_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_if(wr_if),
    .out_if(mem_if)
  );

  assign wr_if.valid = s.push_valid;
  assign wr_if.data = s.push_data;
  // array port belongs to reads; drain stops while any clock enable is low
  assign mem_if.ready = (&cke_s) && (s.rd_st == RD_IDLE);
  assign {pop_idx, pop_mask, pop_data} = mem_if.data;
  assign open0 = s.bank_open[BANKS-1:0];

  // next state: link edges, command decode, power, read and write paths
  always_comb begin
    next_s = s;
    // crossing seen only once both halves of the pair agree
    rise = tck_s & ~cck_s & ~s.link_hi; // RL2
    fall = ~tck_s & cck_s & s.link_hi;
    dqs_rise = dqs_s & ~s.dqs_q;
    dqs_fall = ~dqs_s & s.dqs_q;
    cmd = {ras_n_s, cas_n_s, we_n_s}; // RL1
    ba = {bah_s, bal_s}; // RL10
    sel = {~rs1_n_s, ~rs0_n_s}; // RL9
    ap = addr_s[AP_BIT];
    act_go = '0;
    pre_go = '0;
    rd_go = 1'b0;
    lmr_go = 1'b0;
    if (rise) begin
      next_s.link_hi = 1'b1;
    end else if (fall) begin
      next_s.link_hi = 1'b0;
    end
    next_s.dqs_q = dqs_s;
    next_s.wr_ready = wr_if.ready;
    if (wr_if.valid && wr_if.ready) begin
      next_s.push_valid = 1'b0;
    end

    // per-rank power state and command decoder
    for (int r = 0; r < RANKS; r++) begin
      case (s.pwr[r])
        PWR_ON: begin
          if (rise && !cke_s[r]) begin
            if (sel[r] && cmd == CMD_REF) begin
              next_s.pwr[r] = PWR_SREF; // RL5
            end else if (|s.bank_open[r*BANKS +: BANKS]) begin
              next_s.pwr[r] = PWR_APD; // RL5
            end else begin
              next_s.pwr[r] = PWR_PPD; // RL5
            end
          end else if (rise && sel[r]) begin
            case (cmd) // RL1
              CMD_ACT: begin
                act_go[r] = 1'b1;
                next_s.bank_open[r*BANKS + int'(ba)] = 1'b1; // RL10
              end
              CMD_PRE: begin
                pre_go[r] = 1'b1;
                if (ap) begin
                  next_s.bank_open[r*BANKS +: BANKS] = '0; // RL12
                end else begin
                  next_s.bank_open[r*BANKS + int'(ba)] = 1'b0; // RL12
                end
              end
              CMD_RD: begin
                // one read in flight; a second during a burst is dropped
                if (s.bank_open[r*BANKS + int'(ba)] && s.rd_st == RD_IDLE) begin
                  rd_go = 1'b1;
                  next_s.rd_st = RD_WAIT;
                  next_s.rd_cnt = READ_LATENCY - 1'b1;
                  next_s.rd_idx = {1'(r), ba, addr_s[COL_W-1:0]}; // RL11
                  next_s.rd_rank = 1'(r);
                  if (ap) begin
                    next_s.bank_open[r*BANKS + int'(ba)] = 1'b0; // RL11
                  end
                end
              end
              CMD_WR: begin
                // refused while the fifo cannot take another pair
                if (s.bank_open[r*BANKS + int'(ba)] && !s.wr_pend &&
                    !s.push_valid && s.wr_ready) begin
                  next_s.wr_pend = 1'b1;
                  next_s.wr_lo_ok = 1'b0;
                  next_s.wr_idx = {1'(r), ba, addr_s[COL_W-1:0]}; // RL11
                  next_s.wr_rank = 1'(r);
                  if (ap) begin
                    next_s.bank_open[r*BANKS + int'(ba)] = 1'b0; // RL11
                  end
                end
              end
              CMD_LMR: begin
                lmr_go = 1'b1;
                if (ba == MODE_SEL_BASE) begin
                  next_s.mode_reg = addr_s; // RL13
                end else if (ba == MODE_SEL_EXT) begin
                  next_s.ext_mode = addr_s; // RL13
                end
              end
              default: begin
              end
            endcase
          end
        end
        // commands ignored; only a clocked enable wakes the rank
        PWR_PPD, PWR_APD: begin
          if (rise && cke_s[r]) begin
            next_s.pwr[r] = PWR_ON; // RL6 RL8
          end
        end
        // link clock ignored; enable alone brings the rank back
        PWR_SREF: begin
          if (cke_s[r]) begin
            next_s.pwr[r] = PWR_ON; // RL6 RL8
          end
        end
        default: begin
          next_s.pwr[r] = PWR_ON;
        end
      endcase
    end

    // read launch: low word and strobe high on the rise, high word on fall
    case (s.rd_st)
      RD_WAIT: begin
        if (rise) begin
          if (s.rd_cnt == '0) begin
            next_s.rd_st = RD_BURST;
            next_s.dq = s.mem[s.rd_idx][DATA_W-1:0]; // RL3 RL16
            next_s.dqs = 1'b1; // RL14
            next_s.dq_oe = 1'b1;
            next_s.dqs_oe = 1'b1; // RL17
          end else begin
            next_s.rd_cnt = s.rd_cnt - 1'b1;
          end
        end
      end
      RD_BURST: begin
        if (fall) begin
          next_s.dq = s.mem[s.rd_idx][PAIR_W-1:DATA_W]; // RL3 RL16
          next_s.dqs = 1'b0; // RL14
        end else if (rise) begin
          next_s.dq_oe = 1'b0;
          next_s.dqs_oe = 1'b0; // RL17
          next_s.rd_st = RD_IDLE;
        end
      end
      RD_IDLE: begin
      end
      default: begin
        next_s.rd_st = RD_IDLE;
      end
    endcase
    // enable low drops the drivers at once, with no link edge needed
    // only a read in flight is aborted; an idle path must not kill a new one
    if (s.rd_st != RD_IDLE && !cke_s[s.rd_rank]) begin
      next_s.dq_oe = 1'b0; // RL4 RL6 RL7
      next_s.dqs_oe = 1'b0;
      next_s.rd_st = RD_IDLE;
    end

    // write capture on strobe edges; input buffers follow the enable
    if (s.wr_pend && cke_s[s.wr_rank]) begin // RL4 RL7
      if (dqs_rise) begin
        next_s.wr_lo = dq_s;
        next_s.wr_lo_mask = mask_s;
        next_s.wr_lo_ok = 1'b1;
      end else if (dqs_fall && s.wr_lo_ok) begin
        next_s.push_valid = 1'b1; // RL16
        next_s.push_data = {s.wr_idx, mask_s, s.wr_lo_mask, dq_s, s.wr_lo};
        next_s.wr_pend = 1'b0;
        next_s.wr_lo_ok = 1'b0;
      end
    end

    // array write, byte by byte under the mask
    if (mem_if.valid && mem_if.ready) begin
      for (int b = 0; b < PMASK_W; b++) begin
        if (!pop_mask[b]) begin // RL15
          next_s.mem[pop_idx][b*BYTE_W +: BYTE_W] =
            pop_data[b*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // one register for all state; enums reset to their idle codes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.pwr <= {RANKS{PWR_ON}};
      s.rd_st <= RD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign dq_o = s.dq;
  assign dq_oe_o = s.dq_oe;
  assign data_strobe_o = s.dqs;
  assign data_strobe_oe_o = s.dqs_oe;
  assign mode_reg_o = s.mode_reg;
  assign ext_mode_reg_o = s.ext_mode;
  assign bank_open_o = s.bank_open;
  assign power_state_o = s.pwr;
  assign wr_ready_o = s.wr_ready;

  // checks on rank 0 and the shared data path
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_rank_masked: assert property (rise && rs0_n_s && cke_s[0] && // RL9
    s.pwr[0] == PWR_ON |=> $stable(open0))
    else $error("deselected rank changed its banks");
  a_act_opens: assert property (act_go[0] |=> // RL10
    s.bank_open[$past(ba)])
    else $error("activate did not open the bank");
  a_pre_all: assert property (pre_go[0] && ap |=> open0 == '0) // RL12
    else $error("precharge all left a bank open");
  a_pre_one: assert property (pre_go[0] && !ap |=> // RL12
    !s.bank_open[$past(ba)] && open0 == ($past(open0) & open0))
    else $error("single precharge wrong");
  a_apd_entry: assert property (rise && s.pwr[0] == PWR_ON && // RL5
    !cke_s[0] && !(sel[0] && cmd == CMD_REF) && |open0 |=>
    s.pwr[0] == PWR_APD)
    else $error("active power-down not entered");
  a_sref_entry: assert property (rise && s.pwr[0] == PWR_ON && // RL5
    !cke_s[0] && sel[0] && cmd == CMD_REF |=> s.pwr[0] == PWR_SREF)
    else $error("self refresh not entered");
  a_sref_exit: assert property (s.pwr[0] == PWR_SREF && cke_s[0] // RL6
    |=> s.pwr[0] == PWR_ON)
    else $error("self refresh exit waited for a clock");
  a_pd_sync_exit: assert property (s.pwr[0] == PWR_PPD && !rise // RL6
    |=> s.pwr[0] != PWR_ON)
    else $error("power-down left without a clock crossing");
  a_sref_frozen: assert property (s.pwr[0] == PWR_SREF && // RL8
    !cke_s[0] |=> $stable(open0) && s.pwr[0] == PWR_SREF)
    else $error("self refresh rank reacted to inputs");
  a_read_launch: assert property ($rose(s.dq_oe) |-> // RL3
    $past(rise) && $past(s.rd_st) == RD_WAIT)
    else $error("read data launched off a crossing");
  a_edge_align: assert property (s.dq_oe && $changed(s.dq) |-> // RL14
    $changed(s.dqs))
    else $error("read data moved without its strobe");
  a_strobe_read: assert property (s.dqs_oe |-> s.rd_st == RD_BURST) // RL17
    else $error("strobe driven outside a read burst");
  a_cke_drivers: assert property (!cke_s[s.rd_rank] |=> !s.dq_oe) // RL4
    else $error("drivers on with clock enable low");
  a_wr_pair: assert property ($rose(s.push_valid) |-> // RL16
    $past(dqs_fall) && $past(s.wr_lo_ok))
    else $error("write pair pushed without two strobe edges");
  a_mode_load: assert property (lmr_go && ba == MODE_SEL_BASE |=> // RL13
    s.mode_reg == $past(addr_s))
    else $error("mode register not loaded");
  a_read_accept: assert property (rd_go |=> s.rd_st == RD_WAIT) // RL11
    else $error("accepted read did not start");

  c_read_burst: cover property (s.rd_st == RD_WAIT ##1 s.rd_st == RD_BURST);
  c_self_refresh: cover property (s.pwr[0] == PWR_SREF ##1
    s.pwr[0] == PWR_ON);
  c_active_pd: cover property (s.pwr[0] == PWR_APD);
  c_fifo_full: cover property (!wr_if.ready);
endmodule

// file: hdl/ddrm_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock; full and empty follow the occupancy count
module ddrm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // fill and drain sides
  ddrm_stream_if.snk in_if,
  ddrm_stream_if.src out_if
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } ddrm_fifo_t;
  ddrm_fifo_t s;
  ddrm_fifo_t next_s;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign in_if.ready = (s.cnt != FULL);
  assign out_if.valid = (s.cnt != '0);
  assign out_if.data = s.mem[s.rp];

  // pointer wrap by compare so depth need not be a power of two
  always_comb begin
    next_s = s;
    push = in_if.valid & in_if.ready;
    pop = out_if.valid & out_if.ready;
    if (push) begin
      next_s.mem[s.wp] = in_if.data;
      next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// file: hdl/ddrm_pkg.sv
// constants, command codes and state encodings for the ddr module logic
// assumes a single 125 MHz core clock; all link pins are asynchronous to it
// Functional notes
// RL1 - command decoded from row strobe, column strobe, write enable and rank select
// RL2 - address and control sampled when true clock rises and complement falls
// RL3 - read data and strobe launched on true/complement clock crossings
// RL4 - clock enable high runs clock, buffers and drivers; low stops them
// RL5 - clock enable low: idle banks give precharge power-down or self refresh
// RL6 - power-down entry/exit and self-refresh entry synchronous; rest asynchronous
// RL7 - controller keeps clock enable high through every read and write
// RL8 - power-down keeps clock and enable buffers; self refresh keeps enable only
// RL9 - low rank select enables decoder; high rank select masks every command
// RL10 - bank select inputs name the bank for activate, read, write, precharge
// RL11 - activate carries row; read/write carry column and auto precharge bit
// RL12 - precharge closes named bank, or all banks with auto precharge bit high
// RL13 - mode load: address is opcode, bank select picks base or extended
// RL14 - read strobe edge-aligned with data; write strobe centred by controller
// RL15 - low write mask stores byte, high blocks it, no effect on reads
// RL16 - two data words per clock from one double-width internal transfer
// RL17 - strobe driven by memory only in reads, by controller only in writes
// RL18 - controller selects only the intended rank, holds the other high
package ddrm_pkg;
  localparam int DATA_W = 16;
  localparam int MASK_W = 2;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int RANKS = 2;
  localparam int BANKS = 4;
  localparam int OPEN_W = RANKS * BANKS;
  localparam int COL_W = 2;
  localparam int IDX_W = 1 + BANK_W + COL_W;
  localparam int MEM_N = 1 << IDX_W;
  localparam int PAIR_W = 2 * DATA_W;
  localparam int PMASK_W = 2 * MASK_W;
  localparam int FIFO_W = IDX_W + PMASK_W + PAIR_W;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_W = 9 + RANKS + ADDR_W + 1 + DATA_W + MASK_W;
  localparam int AP_BIT = 10;
  localparam int RD_LAT_W = 3;
  // read latency in link clock cycles; plain default
  localparam logic [RD_LAT_W-1:0] READ_LATENCY = 3'h3;
  // command code {row strobe, column strobe, write enable}, all active low
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [BANK_W-1:0] MODE_SEL_BASE = 2'h0;
  localparam logic [BANK_W-1:0] MODE_SEL_EXT = 2'h1;
  typedef enum logic [3:0] {
    PWR_ON = 4'h1,
    PWR_PPD = 4'h2,
    PWR_APD = 4'h4,
    PWR_SREF = 4'h8
  } ddrm_pwr_t;
  typedef enum logic [2:0] {
    RD_IDLE = 3'h1,
    RD_WAIT = 3'h2,
    RD_BURST = 3'h4
  } ddrm_rd_t;
endpackage

// file: hdl/ddrm_stream_if.sv
// valid/ready word stream between the capture logic, fifo and array
// assumes both ends on the core clock
interface ddrm_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// file: hdl/ddrm_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous pins
// assumes each bit is sampled on its own; no bus coherency is promised
module ddrm_sync #(parameter int W = 1) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // pins in, synchronised out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } ddrm_sync_t;
  ddrm_sync_t s;
  ddrm_sync_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s.meta = d_i;
    next_s.q = s.meta;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;
endmodule
